// ==== ddr_dram_model.sv ====
// behavioural dram and burst source on the sequencer's far side
module ddr_dram_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic burst_req_i,
   input wire logic cke_i,
   input wire logic [2:0] dram_cmd_i,
   input wire logic queue_hold_i,
   output logic burst_busy_o,
   output logic err_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] beat_ff;
   assign burst_busy_o = beat_ff != 4'h0;
   always_ff @(posedge clk_i or posedge rst_i)
      if (rst_i)
      begin
         beat_ff <= 4'h0;
         err_o <= 1'b0;
      end
      else
      begin
         // a started burst runs out, a held queue starts none
         if (beat_ff != 4'h0)
            beat_ff <= beat_ff - 4'h1;
         else if (burst_req_i && !queue_hold_i)
            beat_ff <= 4'hC;
         // a dram with cke low or mid-burst must see no command
         if (dram_cmd_i != ddr_sr_pkg::CMD_NOP && (!cke_i || burst_busy_o))
            err_o <= 1'b1;
      end
endmodule

// ==== ddr_sr_ctrl.sv ====
// self-refresh, activation and start timing sequencer with avalon registers
// How it works
// R1: self-refresh request finishes burst, precharges all, self-refreshes, drops cke
// R2: dram stays in self-refresh until the request bit is written back to 0
// R3: exit waits the self-refresh exit time and then the dll lock time
// R4: queue is only held during self-refresh, so work resumes where it stopped
// R5: after pin entry the host must clear the request bit to leave
// R6: while activate is 0 no commands go out and only registers respond; here a 0 written after start does not stop the sequencer
// R7: activate 1 starts dram initialization, then system requests are accepted
// R8: host waits for the init-done interrupt bit before sending transactions
// R9: every cke level is held at least the programmed minimum pulse cycles
// R10: with auto-precharge on, writes are followed by the programmed recovery wait
// R11: host must program a nonzero auto-precharge write recovery value
// R12: dll lock time counts programmed cycles before the dll is trusted
// R13: after extended mode set the programmed cycles pass before next command
// R14: self-refresh entry pin sets the request bit seen by software
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
module ddr_sr_ctrl (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic sr_enter_pin_i,
   input wire logic burst_busy_i,
   input wire logic wr_autoprecharge_i,
   output logic cke_o,
   output logic [2:0] dram_cmd_o,
   output logic queue_hold_o,
   output logic sys_ready_o,
   output logic ap_recovery_busy_o,
   output logic irq_o
);
   typedef struct packed {
      logic waitreq;
      logic [31:0] rdata;
      logic activate;
      logic srreq;
      logic apflag;
      logic [2:0] tcke;
      logic [3:0] tdal;
      logic [1:0] temrs;
      logic [15:0] tdll;
      logic [7:0] txsr;
      logic [ddr_sr_pkg::INT_W-1:0] ist;
      logic [ddr_sr_pkg::INT_W-1:0] imask;
      logic irq;
      ddr_sr_pkg::seq_state_t state;
      logic cke;
      logic [2:0] cke_cnt;
      logic [2:0] cmd;
      logic hold;
      logic ready;
      logic pin_meta;
      logic pin_sync;
      logic pin_prev;
   } ctrl_state_t;

   ctrl_state_t cur_ff;
   ctrl_state_t nxt_cur;
   logic seq_load;
   logic [15:0] seq_value;
   logic seq_busy;
   logic ap_load;
   logic ap_busy;

   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      return (old & ~m) | (wd & m);
   endfunction

   wait_counter #(.W(16)) seq_wait (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(seq_load),
      .value_i(seq_value),
      .busy_o(seq_busy)
   );

   wait_counter #(.W(4)) ap_wait (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(ap_load),
      .value_i(cur_ff.tdal),
      .busy_o(ap_busy)
   );

   // recovery wait is armed by each write with auto-precharge while enabled and in S_RUN
   assign ap_load = cur_ff.apflag && wr_autoprecharge_i
                    && cur_ff.state == ddr_sr_pkg::S_RUN; // [R10]

   always_comb
   begin
      logic req;
      logic accept;
      logic [31:0] wdm;
      logic [ddr_sr_pkg::INT_W-1:0] ev;
      logic cke_may_move;
      logic want_cke;
      req = 1'b0;
      accept = 1'b0;
      wdm = '0;
      ev = '0;
      cke_may_move = 1'b0;
      want_cke = 1'b0;
      nxt_cur = cur_ff;
      seq_load = 1'b0;
      seq_value = '0;
      // pin synchroniser and rising-edge detect on the settled copy
      nxt_cur.pin_meta = sr_enter_pin_i;
      nxt_cur.pin_sync = cur_ff.pin_meta;
      nxt_cur.pin_prev = cur_ff.pin_sync;
      // bus slave: one wait cycle, then waitrequest low for one cycle
      req = avs_read_i || avs_write_i;
      accept = req && !cur_ff.waitreq;
      nxt_cur.waitreq = 1'b1;
      if (req && cur_ff.waitreq)
      begin
         nxt_cur.waitreq = 1'b0;
         nxt_cur.rdata = '0;
         unique case (avs_address_i)
            ddr_sr_pkg::CTRL_OFF:
            begin
               nxt_cur.rdata[ddr_sr_pkg::ACT_BIT] = cur_ff.activate;
               nxt_cur.rdata[ddr_sr_pkg::SRREQ_BIT] = cur_ff.srreq;
               nxt_cur.rdata[ddr_sr_pkg::APFLAG_BIT] = cur_ff.apflag;
            end
            ddr_sr_pkg::TIMING_OFF:
            begin
               nxt_cur.rdata[ddr_sr_pkg::TCKE_LSB +: 3] = cur_ff.tcke;
               nxt_cur.rdata[ddr_sr_pkg::TDAL_LSB +: 4] = cur_ff.tdal;
               nxt_cur.rdata[ddr_sr_pkg::TEMRS_LSB +: 2] = cur_ff.temrs;
            end
            ddr_sr_pkg::DLL_OFF: nxt_cur.rdata[15:0] = cur_ff.tdll;
            ddr_sr_pkg::TXSR_OFF: nxt_cur.rdata[7:0] = cur_ff.txsr;
            ddr_sr_pkg::STATE_OFF:
               nxt_cur.rdata[7:0] = {ap_busy, cur_ff.cke, cur_ff.ready,
                                     cur_ff.state == ddr_sr_pkg::S_SR_HOLD,
                                     4'(cur_ff.state)};
            ddr_sr_pkg::INT_STAT_OFF:
               nxt_cur.rdata[ddr_sr_pkg::INT_W-1:0] = cur_ff.ist;
            ddr_sr_pkg::INT_MASK_OFF:
               nxt_cur.rdata[ddr_sr_pkg::INT_W-1:0] = cur_ff.imask;
            default: nxt_cur.rdata = '0;
         endcase
      end
      if (accept && avs_write_i)
      begin
         unique case (avs_address_i)
            ddr_sr_pkg::CTRL_OFF:
            begin
               wdm = be_merge({29'h0, cur_ff.apflag, cur_ff.srreq,
                               cur_ff.activate}, avs_writedata_i,
                              avs_byteenable_i);
               nxt_cur.activate = wdm[ddr_sr_pkg::ACT_BIT];
               nxt_cur.srreq = wdm[ddr_sr_pkg::SRREQ_BIT];
               nxt_cur.apflag = wdm[ddr_sr_pkg::APFLAG_BIT];
            end
            ddr_sr_pkg::TIMING_OFF:
            begin
               wdm = be_merge({22'h0, cur_ff.temrs, cur_ff.tdal, 1'b0,
                               cur_ff.tcke}, avs_writedata_i,
                              avs_byteenable_i);
               nxt_cur.tcke = wdm[ddr_sr_pkg::TCKE_LSB +: 3];
               nxt_cur.tdal = wdm[ddr_sr_pkg::TDAL_LSB +: 4];
               nxt_cur.temrs = wdm[ddr_sr_pkg::TEMRS_LSB +: 2];
            end
            ddr_sr_pkg::DLL_OFF:
            begin
               wdm = be_merge({16'h0, cur_ff.tdll}, avs_writedata_i,
                              avs_byteenable_i);
               nxt_cur.tdll = wdm[15:0];
            end
            ddr_sr_pkg::TXSR_OFF:
            begin
               wdm = be_merge({24'h0, cur_ff.txsr}, avs_writedata_i,
                              avs_byteenable_i);
               nxt_cur.txsr = wdm[7:0];
            end
            ddr_sr_pkg::INT_STAT_OFF:
               if (avs_byteenable_i[0])
                  nxt_cur.ist = cur_ff.ist
                                & ~avs_writedata_i[ddr_sr_pkg::INT_W-1:0];
            ddr_sr_pkg::INT_MASK_OFF:
               if (avs_byteenable_i[0])
                  nxt_cur.imask = avs_writedata_i[ddr_sr_pkg::INT_W-1:0];
            default: ;
         endcase
      end
      // pin entry is only honoured once the controller is active
      if (cur_ff.activate && cur_ff.pin_sync && !cur_ff.pin_prev)
         nxt_cur.srreq = 1'b1; // [R14] [R5]
      // cke may only change once the current level is old enough
      if (cur_ff.cke_cnt >= cur_ff.tcke)
         cke_may_move = 1'b1; // [R9]
      want_cke = cur_ff.cke;
      nxt_cur.cmd = ddr_sr_pkg::CMD_NOP;
      unique case (cur_ff.state)
         ddr_sr_pkg::S_OFF:
         begin
            nxt_cur.ready = 1'b0; // [R6]
            if (cur_ff.activate)
               nxt_cur.state = ddr_sr_pkg::S_INIT_PRE; // [R7]
         end
         ddr_sr_pkg::S_INIT_PRE:
         begin
            want_cke = 1'b1;
            if (cur_ff.cke && cke_may_move)
            begin
               nxt_cur.cmd = ddr_sr_pkg::CMD_PRECHARGE_ALL;
               nxt_cur.state = ddr_sr_pkg::S_INIT_EMRS;
            end
         end
         ddr_sr_pkg::S_INIT_EMRS:
         begin
            nxt_cur.cmd = ddr_sr_pkg::CMD_EXT_MODE_SET;
            seq_load = 1'b1;
            seq_value = {14'h0, cur_ff.temrs}; // [R13]
            nxt_cur.state = ddr_sr_pkg::S_EMRS_WAIT;
         end
         ddr_sr_pkg::S_EMRS_WAIT:
            if (!seq_busy)
               nxt_cur.state = ddr_sr_pkg::S_INIT_MRS; // [R13]
         ddr_sr_pkg::S_INIT_MRS:
         begin
            nxt_cur.cmd = ddr_sr_pkg::CMD_MODE_SET_DLL;
            seq_load = 1'b1;
            seq_value = cur_ff.tdll; // [R12]
            nxt_cur.state = ddr_sr_pkg::S_DLL_WAIT;
         end
         ddr_sr_pkg::S_DLL_WAIT:
            if (!seq_busy)
            begin
               ev[ddr_sr_pkg::INT_INIT_DONE] = 1'b1; // [R8] [R12]
               nxt_cur.ready = 1'b1; // [R7]
               nxt_cur.state = ddr_sr_pkg::S_RUN;
            end
         ddr_sr_pkg::S_RUN:
            if (cur_ff.srreq)
            begin
               nxt_cur.hold = 1'b1; // [R1] [R4]
               nxt_cur.state = ddr_sr_pkg::S_SR_DRAIN;
            end
         ddr_sr_pkg::S_SR_DRAIN:
            // the burst in flight ends and the recovery wait runs out first
            if (!burst_busy_i && !ap_busy)
               nxt_cur.state = ddr_sr_pkg::S_SR_PRE; // [R1]
         ddr_sr_pkg::S_SR_PRE:
         begin
            nxt_cur.cmd = ddr_sr_pkg::CMD_PRECHARGE_ALL; // [R1]
            nxt_cur.state = ddr_sr_pkg::S_SR_CMD;
         end
         ddr_sr_pkg::S_SR_CMD:
         begin
            nxt_cur.cmd = ddr_sr_pkg::CMD_SELF_REFRESH; // [R1]
            nxt_cur.state = ddr_sr_pkg::S_SR_CKE;
         end
         ddr_sr_pkg::S_SR_CKE:
         begin
            want_cke = 1'b0; // [R1]
            if (!cur_ff.cke)
            begin
               ev[ddr_sr_pkg::INT_SR_ENTERED] = 1'b1;
               nxt_cur.state = ddr_sr_pkg::S_SR_HOLD;
            end
         end
         ddr_sr_pkg::S_SR_HOLD:
            if (!cur_ff.srreq)
               nxt_cur.state = ddr_sr_pkg::S_SR_EXIT; // [R2]
         ddr_sr_pkg::S_SR_EXIT:
         begin
            want_cke = 1'b1;
            if (cur_ff.cke)
            begin
               seq_load = 1'b1;
               seq_value = {8'h0, cur_ff.txsr}; // [R3]
               nxt_cur.state = ddr_sr_pkg::S_SR_XSR;
            end
         end
         ddr_sr_pkg::S_SR_XSR:
            if (!seq_busy)
            begin
               seq_load = 1'b1;
               seq_value = cur_ff.tdll; // [R3] [R12]
               nxt_cur.state = ddr_sr_pkg::S_SR_DLL;
            end
         ddr_sr_pkg::S_SR_DLL:
            if (!seq_busy)
            begin
               ev[ddr_sr_pkg::INT_SR_EXITED] = 1'b1;
               nxt_cur.hold = 1'b0; // [R4]
               nxt_cur.state = ddr_sr_pkg::S_RUN; // [R3]
            end
      endcase
      // cke follows the sequencer only when the pulse width allows it
      if (want_cke != cur_ff.cke && cke_may_move)
      begin
         nxt_cur.cke = want_cke; // [R9]
         nxt_cur.cke_cnt = 3'h1;
      end
      else if (cur_ff.cke_cnt != ddr_sr_pkg::CKE_CNT_MAX)
         nxt_cur.cke_cnt = cur_ff.cke_cnt + 3'h1;
      // a hardware event beats a software clear in the same cycle
      nxt_cur.ist = nxt_cur.ist | ev;
      nxt_cur.irq = |(nxt_cur.ist & nxt_cur.imask);
   end
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cur_ff <= '{waitreq: 1'b1, rdata: 32'h0, activate: 1'b0,
                     srreq: 1'b0, apflag: 1'b0,
                     tcke: ddr_sr_pkg::TCKE_RST, tdal: ddr_sr_pkg::TDAL_RST,
                     temrs: ddr_sr_pkg::TEMRS_RST,
                     tdll: ddr_sr_pkg::TDLL_RST, txsr: ddr_sr_pkg::TXSR_RST,
                     ist: '0, imask: '0, irq: 1'b0,
                     state: ddr_sr_pkg::S_OFF, cke: 1'b0,
                     cke_cnt: ddr_sr_pkg::CKE_CNT_MAX,
                     cmd: ddr_sr_pkg::CMD_NOP, hold: 1'b0, ready: 1'b0,
                     pin_meta: 1'b0, pin_sync: 1'b0, pin_prev: 1'b0};
      end
      else
      begin
         cur_ff <= nxt_cur;
      end
   end
   assign avs_readdata_o = cur_ff.rdata;
   assign avs_waitrequest_o = cur_ff.waitreq;
   assign cke_o = cur_ff.cke;
   assign dram_cmd_o = cur_ff.cmd;
   assign queue_hold_o = cur_ff.hold;
   assign sys_ready_o = cur_ff.ready;
   assign ap_recovery_busy_o = ap_busy;
   assign irq_o = cur_ff.irq;
endmodule

// ==== ddr_sr_ctrl_chk.sv ====
// port-level assertions for the self-refresh and start sequencer
module ddr_sr_ctrl_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic avs_waitrequest_o,
   input wire logic burst_busy_i,
   input wire logic wr_autoprecharge_i,
   input wire logic cke_o,
   input wire logic [2:0] dram_cmd_o,
   input wire logic queue_hold_o,
   input wire logic sys_ready_o,
   input wire logic ap_recovery_busy_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wacc;
   logic act_ff, clr_ff, srcmd_ff, cke_ff;
   logic [2:0] tcke_ff, run_ff, emrs_ff;
   logic [1:0] temrs_ff;
   logic [3:0] tdal_ff, ap_ff;
   logic [7:0] txsr_ff;
   logic [15:0] tdll_ff;
   logic [17:0] exit_ff;
   // shadows of the registers, taken from accepted bus writes
   assign wacc = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
   always_ff @(posedge clk_i or posedge rst_i)
      if (rst_i)
      begin
         act_ff <= 1'b0;
         clr_ff <= 1'b1;
         emrs_ff <= 3'h7;
         temrs_ff <= ddr_sr_pkg::TEMRS_RST;
         srcmd_ff <= 1'b0;
         cke_ff <= 1'b0;
         tcke_ff <= ddr_sr_pkg::TCKE_RST;
         run_ff <= 3'h7;
         tdal_ff <= ddr_sr_pkg::TDAL_RST;
         ap_ff <= 4'h0;
         txsr_ff <= ddr_sr_pkg::TXSR_RST;
         tdll_ff <= ddr_sr_pkg::TDLL_RST;
         exit_ff <= 18'h0;
      end
      else
      begin
         cke_ff <= cke_o;
         run_ff <= (cke_o != cke_ff) ? 3'h1 : run_ff + {2'h0, run_ff != 3'h7};
         exit_ff <= (cke_o && !cke_ff) ? 18'h1 :
            exit_ff + {17'h0, exit_ff != 18'h3FFFF};
         ap_ff <= ap_recovery_busy_o ? ap_ff + 4'h1 : 4'h0;
         emrs_ff <= (dram_cmd_o == ddr_sr_pkg::CMD_EXT_MODE_SET) ? 3'h1 :
            emrs_ff + {2'h0, emrs_ff != 3'h7};
         if (dram_cmd_o == ddr_sr_pkg::CMD_SELF_REFRESH)
            srcmd_ff <= 1'b1;
         else if (cke_o && !cke_ff)
            srcmd_ff <= 1'b0;
         // clr_ff shadows a cleared request; a clear may land before entry
         if (wacc && avs_address_i == ddr_sr_pkg::CTRL_OFF)
         begin
            act_ff <= act_ff | avs_writedata_i[ddr_sr_pkg::ACT_BIT];
            clr_ff <= !avs_writedata_i[ddr_sr_pkg::SRREQ_BIT];
         end
         if (wacc && avs_address_i == ddr_sr_pkg::TIMING_OFF)
         begin
            tcke_ff <= avs_writedata_i[ddr_sr_pkg::TCKE_LSB +: 3];
            tdal_ff <= avs_writedata_i[ddr_sr_pkg::TDAL_LSB +: 4];
            temrs_ff <= avs_writedata_i[ddr_sr_pkg::TEMRS_LSB +: 2];
         end
         if (wacc && avs_address_i == ddr_sr_pkg::DLL_OFF)
            tdll_ff <= avs_writedata_i[15:0];
         if (wacc && avs_address_i == ddr_sr_pkg::TXSR_OFF)
            txsr_ff <= avs_writedata_i[7:0];
      end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wait_one_a:
      assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
         |=> !avs_waitrequest_o) else $error("no answer one cycle on");
   wait_stands_a:
      assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
         else $error("waitrequest low longer than a cycle");
   idle_quiet_a:
      assert property (!act_ff |-> dram_cmd_o == ddr_sr_pkg::CMD_NOP
         && !cke_o && !sys_ready_o) else $error("activity while inactive");
   cke_pulse_a:
      assert property (cke_o != cke_ff |-> run_ff >= tcke_ff)
         else $error("cke level shorter than minimum");
   sr_drain_a:
      assert property (dram_cmd_o == ddr_sr_pkg::CMD_PRECHARGE_ALL
         && sys_ready_o |-> queue_hold_o && !burst_busy_i
         && !ap_recovery_busy_o) else $error("precharge inside burst");
   sr_enter_a:
      assert property ($fell(cke_o) && sys_ready_o |-> srcmd_ff
         && queue_hold_o) else $error("cke dropped without self-refresh");
   sr_stay_a:
      assert property ($rose(cke_o) && sys_ready_o |-> clr_ff)
         else $error("self-refresh left while requested");
   exit_wait_a:
      assert property ($fell(queue_hold_o) && sys_ready_o
         |-> exit_ff >= 18'(txsr_ff) + 18'(tdll_ff))
         else $error("exit shorter than exit and lock time");
   ap_start_a:
      assert property ($rose(ap_recovery_busy_o) |-> $past(wr_autoprecharge_i))
         else $error("recovery wait without a write");
   ap_len_a:
      assert property ($fell(ap_recovery_busy_o) |-> ap_ff == tdal_ff)
         else $error("recovery wait length wrong");
   emrs_gap_a:
      assert property (dram_cmd_o == ddr_sr_pkg::CMD_MODE_SET_DLL
         |-> emrs_ff > {1'b0, temrs_ff})
         else $error("command too soon after extended mode set");
endmodule
bind ddr_sr_ctrl ddr_sr_ctrl_chk ddr_sr_ctrl_chk_inst (.clk_i(clk_i),
   .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_byteenable_i(avs_byteenable_i), .avs_waitrequest_o(avs_waitrequest_o),
   .burst_busy_i(burst_busy_i), .wr_autoprecharge_i(wr_autoprecharge_i),
   .cke_o(cke_o), .dram_cmd_o(dram_cmd_o), .queue_hold_o(queue_hold_o),
   .sys_ready_o(sys_ready_o), .ap_recovery_busy_o(ap_recovery_busy_o));

// ==== ddr_sr_pkg.sv ====
// constants and types shared by the self-refresh and start timing block
package ddr_sr_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] TIMING_OFF = 8'h04;
   localparam logic [7:0] DLL_OFF = 8'h08;
   localparam logic [7:0] TXSR_OFF = 8'h0C;
   localparam logic [7:0] STATE_OFF = 8'h10;
   localparam logic [7:0] INT_STAT_OFF = 8'h14;
   localparam logic [7:0] INT_MASK_OFF = 8'h18;
   // control register bits
   localparam int ACT_BIT = 0;
   localparam int SRREQ_BIT = 1;
   localparam int APFLAG_BIT = 2;
   // timing register fields
   localparam int TCKE_LSB = 0;
   localparam int TDAL_LSB = 4;
   localparam int TEMRS_LSB = 8;
   // interrupt bits
   localparam int INT_INIT_DONE = 0;
   localparam int INT_SR_ENTERED = 1;
   localparam int INT_SR_EXITED = 2;
   localparam int INT_W = 3;
   // reset values
   localparam logic [2:0] TCKE_RST = 3'h3;
   localparam logic [3:0] TDAL_RST = 4'h4;
   localparam logic [1:0] TEMRS_RST = 2'h2;
   localparam logic [15:0] TDLL_RST = 16'h00C8;
   localparam logic [7:0] TXSR_RST = 8'hC8;
   localparam logic [2:0] CKE_CNT_MAX = 3'h7;
   // dram command codes
   localparam logic [2:0] CMD_NOP = 3'h0;
   localparam logic [2:0] CMD_PRECHARGE_ALL = 3'h1;
   localparam logic [2:0] CMD_SELF_REFRESH = 3'h2;
   localparam logic [2:0] CMD_EXT_MODE_SET = 3'h3;
   localparam logic [2:0] CMD_MODE_SET_DLL = 3'h4;
   typedef enum logic [3:0] {
      S_OFF, S_INIT_PRE, S_INIT_EMRS, S_EMRS_WAIT, S_INIT_MRS, S_DLL_WAIT,
      S_RUN, S_SR_DRAIN, S_SR_PRE, S_SR_CMD, S_SR_CKE, S_SR_HOLD,
      S_SR_EXIT, S_SR_XSR, S_SR_DLL
   } seq_state_t;
endpackage

// ==== test_ddr_selfrefresh_start_timing.sv ====
// self-checking random bench for the self-refresh and start sequencer
module test_ddr_selfrefresh_start_timing;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic rd = 1'b0, wr = 1'b0, pin = 1'b0, bq = 1'b0, wap = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0, rdat, v, tw;
   logic wrq, bb, cke, hold, rdy, apb, irq, err;
   logic [2:0] cmd, tcke;
   logic [3:0] tdal;
   logic [7:0] dly;
   logic [2:0] cmds[$];
   int miscompares = 0, check_count = 0, k, n;
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i)
      if (cmd !== 3'h0)
         cmds.push_back(cmd);
   ddr_sr_ctrl ddr_sr_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wrq), .sr_enter_pin_i(pin), .burst_busy_i(bb),
      .wr_autoprecharge_i(wap), .cke_o(cke), .dram_cmd_o(cmd),
      .queue_hold_o(hold), .sys_ready_o(rdy), .ap_recovery_busy_o(apb),
      .irq_o(irq));
   ddr_dram_model ddr_dram_model_inst (.clk_i(clk_i), .rst_i(rst_i),
      .burst_req_i(bq), .cke_i(cke), .dram_cmd_i(cmd), .queue_hold_i(hold),
      .burst_busy_o(bb), .err_o(err));
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, got);
      check_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   // packs the commands seen since the last call, oldest first
   task automatic chk_cmds(input string what, input logic [11:0] exp);
      logic [11:0] got;
      got = 12'h0;
      foreach (cmds[i])
         got = {got[8:0], cmds[i]};
      chk(what, {20'h0, exp}, {20'h0, got});
      cmds.delete();
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      adr <= a;
      wd <= d;
      rd <= !w;
      wr <= w;
      k = 0;
      do
      begin
         @(posedge clk_i);
         k++;
      end while (wrq !== 1'b0 && k < 50);
      v = rdat;
      if (k >= 50)
      begin
         miscompares++;
         results();
      end
      rd <= 1'b0;
      wr <= 1'b0;
      // one idle edge keeps the request lines single-driven per step
      @(posedge clk_i);
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk("register", exp, v);
   endtask
   function automatic logic pick(input int sel);
      return sel == 0 ? rdy : (sel == 1 ? hold : cke);
   endfunction
   // timing register image built from its three fields
   function automatic logic [31:0] timing_word(input logic [1:0] emrs,
      input logic [3:0] dal, input logic [2:0] ck);
      return (32'(emrs) << ddr_sr_pkg::TEMRS_LSB)
         | (32'(dal) << ddr_sr_pkg::TDAL_LSB)
         | (32'(ck) << ddr_sr_pkg::TCKE_LSB);
   endfunction
   task automatic wait_for(input int sel, input logic lvl);
      n = 0;
      while (pick(sel) !== lvl && n < 2000)
      begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 2000)
      begin
         miscompares++;
         results();
      end
   endtask
   initial
   begin
      v = $urandom(9547);
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rreg(ddr_sr_pkg::CTRL_OFF, 32'h0);
      rreg(ddr_sr_pkg::TIMING_OFF, timing_word(ddr_sr_pkg::TEMRS_RST,
         ddr_sr_pkg::TDAL_RST, ddr_sr_pkg::TCKE_RST));
      rreg(ddr_sr_pkg::DLL_OFF, {16'h0, ddr_sr_pkg::TDLL_RST});
      rreg(ddr_sr_pkg::TXSR_OFF, {24'h0, ddr_sr_pkg::TXSR_RST});
      bus(1'b1, 8'h1C, 32'hFFFFFFFF);
      rreg(8'h1C, 32'h0);
      pin <= 1'b1;
      bq <= 1'b1;
      repeat (6) @(posedge clk_i);
      pin <= 1'b0;
      bq <= 1'b0;
      repeat (20) @(posedge clk_i);
      rreg(ddr_sr_pkg::CTRL_OFF, 32'h0);
      chk_cmds("idle commands", 12'h0);
      chk("idle cke", 32'h0, {31'h0, cke});
      tcke = 3'($urandom_range(7, 1));
      dly = 8'($urandom_range(8, 1));
      bus(1'b1, ddr_sr_pkg::DLL_OFF, {24'h0, dly});
      bus(1'b1, ddr_sr_pkg::TXSR_OFF, {24'h0, dly});
      bus(1'b1, ddr_sr_pkg::INT_MASK_OFF, 32'h5);
      bus(1'b1, ddr_sr_pkg::CTRL_OFF, 32'h1);
      wait_for(0, 1'b1);
      chk_cmds("init commands", {3'h0, ddr_sr_pkg::CMD_PRECHARGE_ALL,
         ddr_sr_pkg::CMD_EXT_MODE_SET, ddr_sr_pkg::CMD_MODE_SET_DLL});
      rreg(ddr_sr_pkg::INT_STAT_OFF, 32'h1);
      chk("irq", 32'h1, {31'h0, irq});
      bus(1'b1, ddr_sr_pkg::INT_STAT_OFF, 32'h1);
      rreg(ddr_sr_pkg::INT_STAT_OFF, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         tdal = 4'($urandom_range(15, 1));
         tw = timing_word(2'($urandom), tdal, tcke);
         bus(1'b1, ddr_sr_pkg::TIMING_OFF, tw);
         rreg(ddr_sr_pkg::TIMING_OFF, tw);
         bus(1'b1, ddr_sr_pkg::CTRL_OFF, (i == 0) ? 32'h1 : 32'h5);
         wap <= 1'b1;
         @(posedge clk_i);
         wap <= 1'b0;
         k = 0;
         repeat (20) @(posedge clk_i) k += int'(apb === 1'b1);
         chk("ap busy cycles", (i == 0) ? 32'h0 : {28'h0, tdal}, k);
      end
      bus(1'b1, ddr_sr_pkg::CTRL_OFF, 32'h1);
      bq <= 1'b1;
      @(posedge clk_i);
      bq <= 1'b0;
      bus(1'b1, ddr_sr_pkg::CTRL_OFF, 32'h3);
      wait_for(2, 1'b0);
      chk_cmds("entry commands", {6'h0, ddr_sr_pkg::CMD_PRECHARGE_ALL,
         ddr_sr_pkg::CMD_SELF_REFRESH});
      rreg(ddr_sr_pkg::INT_STAT_OFF, 32'h2);
      chk("masked irq", 32'h0, {31'h0, irq});
      repeat (30) @(posedge clk_i);
      chk("held sr", 32'h1, {31'h0, hold && !cke});
      bus(1'b1, ddr_sr_pkg::CTRL_OFF, 32'h1);
      wait_for(1, 1'b0);
      chk("exit wait", 32'h1, {31'h0, n + 1 >= 2 * dly});
      chk_cmds("exit commands", 12'h0);
      rreg(ddr_sr_pkg::INT_STAT_OFF, 32'h6);
      chk("irq", 32'h1, {31'h0, irq});
      bus(1'b1, ddr_sr_pkg::INT_STAT_OFF, 32'h6);
      pin <= 1'b1;
      repeat (4) @(posedge clk_i);
      pin <= 1'b0;
      wait_for(2, 1'b0);
      rreg(ddr_sr_pkg::CTRL_OFF, 32'h3);
      bus(1'b1, ddr_sr_pkg::CTRL_OFF, 32'h1);
      wait_for(1, 1'b0);
      // quick entry then exit at the widest pulse: cke low must still last
      bus(1'b1, ddr_sr_pkg::TIMING_OFF, timing_word(2'h0, 4'h1, 3'h7));
      bus(1'b1, ddr_sr_pkg::CTRL_OFF, 32'h3);
      bus(1'b1, ddr_sr_pkg::CTRL_OFF, 32'h1);
      k = 0;
      repeat (40) @(posedge clk_i) k += int'(cke === 1'b0);
      chk("cke low cycles", 32'h1, {31'h0, k >= 7});
      wait_for(1, 1'b0);
      chk("dram errors", 32'h0, {31'h0, err});
      results();
   end
endmodule

// ==== wait_counter.sv ====
// loadable down counter whose busy flag stands for exactly the loaded count
module wait_counter #(
   parameter int W = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire logic [W-1:0] value_i,
   output logic busy_o
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic busy;
   } cnt_state_t;

   cnt_state_t cur_ff;
   cnt_state_t nxt_cur;

   always_comb
   begin
      nxt_cur = cur_ff;
      if (load_i)
      begin
         nxt_cur.cnt = value_i;
         nxt_cur.busy = (value_i != '0);
      end
      else if (cur_ff.cnt > W'(1))
      begin
         nxt_cur.cnt = cur_ff.cnt - W'(1);
      end
      else
      begin
         nxt_cur.cnt = '0;
         nxt_cur.busy = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cur_ff <= '0;
      end
      else
      begin
         cur_ff <= nxt_cur;
      end
   end

   assign busy_o = cur_ff.busy;
endmodule
